// *** bench/frame_host_model.sv ***
`timescale 1ns/1ns
module frame_host_model (
  input  wire logic        clock,    // Pixel clock.
  input  wire logic        srst,     // Synchronous reset, active high.
  input  wire logic [7:0]  outPixel, // Pixel from the camera side.
  input  wire logic        outValid, // Pixel valid.
  input  wire logic        outSof,   // First pixel of a frame.
  output logic      [15:0] column,   // Next column expected in row 0.
  output logic      [15:0] frames    // Frames received so far.
);
  // The receiver has no back-pressure, so it only counts what arrives.
  // A frame start resets the column, since metadata is anchored at column 0.
  always_ff @(posedge clock) begin
    if (srst) begin
      column <= 16'h0000;
      frames <= 16'h0000;
    end else if (outValid) begin
      column <= outSof ? 16'h0001 : column + 16'h0001;
      frames <= frames + {15'h0000, outSof};
    end
  end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ns
module tb;
  import embedder_pkg::*;
  typedef struct {logic [31:0] val; logic [31:0] care; logic err;} rd_s;
  typedef struct {logic [7:0] val; logic [7:0] care; logic sof;} px_s;
  logic        clock = 0, srst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic        integrationEnd = 0, inValid = 0, inSof = 0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [7:0]  inPixel = 8'h00;
  logic [31:0] vals [10] = '{default: 32'h0}; // Item input words, by item index.
  logic [31:0] prdata;
  logic        pready, pslverr, outValid, outSof;
  logic [7:0]  outPixel;
  logic [15:0] column, frames;
  int          mismatches = 0, checks = 0, cyc = 0, fc = 0;
  rd_s         expRd[$];
  px_s         expPx[$];

  frame_host_model host (.clock(clock), .srst(srst), .outPixel(outPixel), .outValid(outValid),
    .outSof(outSof), .column(column), .frames(frames));
  frame_metadata_embedder #(.SUB_MAX(12'h003)) dut (.clock(clock), .srst(srst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .inPixel(inPixel),
    .inValid(inValid), .inSof(inSof), .outPixel(outPixel), .outValid(outValid),
    .outSof(outSof), .integrationEnd(integrationEnd), .gainValue(vals[1]),
    .shutterValue(vals[2]), .brightnessValue(vals[3]), .exposureValue(vals[4]),
    .whiteBalanceValue(vals[5]), .strobeCount(vals[7]), .regionLeft(vals[9][31:16]),
    .regionTop(vals[9][15:0]), .gpioPins(vals[8][3:0]));

  // Clock at 50 MHz.
  always #10 clock = ~clock;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One APB transfer; it waits an edge first so a release never meets a new setup.
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] e, input logic [31:0] c,
                     input logic err);
    expRd.push_back('{e, c, err});
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One frame: latch values, disturb them afterwards, then stream 48 pixels.
  task automatic frame(input logic [9:0] en);
    logic [31:0] snap [10];
    logic [7:0]  px;
    int          nm;
    apb(1'b1, 16'h12f8, {22'h0, en}, 4'hf, 32'h0, 32'h0, 1'b0);
    for (int i = 0; i < 10; i++) vals[i] <= (i == 8) ? ($urandom & 32'hf) : $urandom;
    repeat (6) @(posedge clock); // Pin filter needs settled pins before the latch.
    integrationEnd <= 1'b1;
    snap = vals;
    snap[6] = fc; // Frame count before this latch.
    fc++;
    @(posedge clock);
    integrationEnd <= 1'b0;
    for (int i = 0; i < 10; i++) vals[i] <= (i == 8) ? (~vals[i] & 32'hf) : ~vals[i];
    // The metadata byte count is kept apart, since the watcher drains the queue meanwhile.
    nm = 0;
    for (int i = 0; i < 10; i++)
      if (en[i])
        for (int b = 0; b < 4; b++) begin
          expPx.push_back('{(i == 0) ? 8'h00 : snap[i][31-8*b -: 8],
                            (i == 0 && b > 0) ? 8'h00 : 8'hff, nm == 0});
          nm++;
        end
    for (int n = 0; n < 48; n++) begin
      @(posedge clock);
      px = 8'($urandom);
      inValid <= 1'b1;
      inSof <= (n == 0);
      inPixel <= px;
      if (n >= nm) expPx.push_back('{px, 8'hff, n == 0});
    end
    @(posedge clock);
    inValid <= 1'b0;
    inSof <= 1'b0;
    repeat (3) @(posedge clock);
    $display("test frame %h done", en);
  endtask

  // Pixel results: a pixel with no promise left is a mismatch too.
  task automatic comparePixel;
    px_s p;
    checks++;
    if (expPx.size() == 0) begin
      mismatches++;
      $display("[FAIL] %0t pixel %h arrived unannounced", $time, outPixel);
    end else begin
      p = expPx.pop_front();
      if ((outPixel & p.care) !== (p.val & p.care) || outSof !== p.sof) begin
        mismatches++;
        $display("[FAIL] %0t pixel %h sof %b expected %h sof %b", $time, outPixel, outSof,
                 p.val, p.sof);
      end
    end
  endtask

  // Register answers: read data under its care mask and the error flag.
  task automatic compareRead;
    rd_s r;
    checks++;
    if (expRd.size() == 0) begin
      mismatches++;
      $display("[FAIL] %0t bus answer arrived unannounced", $time);
    end else begin
      r = expRd.pop_front();
      if ((prdata & r.care) !== (r.val & r.care) || pslverr !== r.err) begin
        mismatches++;
        $display("[FAIL] %0t read %h err %b expected %h err %b", $time, prdata, pslverr,
                 r.val, r.err);
      end
    end
  endtask

  // Results are taken off the queues in the order they were promised.
  always @(posedge clock) begin
    if (outValid === 1'b1) comparePixel();
    if (psel && penable && pready === 1'b1) compareRead();
  end

  // A hang is cut short well past the few hundred cycles the run needs.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("[FAIL] %0t run did not finish", $time);
      stop_test;
    end
  end

  initial begin
    void'($urandom(32651));
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    apb(1'b0, 16'h12f8, 32'h0, 4'h0, 32'h83ff0000, 32'hffffffff, 1'b0);
    apb(1'b1, 16'h12f8, 32'hffffffff, 4'hf, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 16'h12f8, 32'h0, 4'h0, 32'h83ff03ff, 32'hffffffff, 1'b0);
    apb(1'b1, 16'h12f8, 32'h0, 4'he, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 16'h12f8, 32'h0, 4'h0, 32'h83ff00ff, 32'hffffffff, 1'b0);
    apb(1'b1, 16'h12fc, 32'h0, 4'hf, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 16'h12fc, 32'h0, 4'h0, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b0, 16'h12f8, 32'h0, 4'h0, 32'h83ff00ff, 32'hffffffff, 1'b0);
    $display("test registers done");
    frame(10'h3ff);
    frame(10'h004);
    frame(10'h200);
    frame(10'h000);
    frame(10'($urandom));
    checks++;
    if (frames !== 16'h0005 || column !== 16'h0030 || expPx.size() != 0 ||
        expRd.size() != 0) begin
      mismatches++;
      $display("[FAIL] %0t frames %0d pending %0d", $time, frames, expPx.size());
    end
    // A setup that meets a low clock enable must still be answered once it rises.
    apb(1'b1, 16'h12f8, 32'h155, 4'hf, 32'h0, 32'h0, 1'b0);
    ce <= 1'b0;
    fork
      apb(1'b0, 16'h12f8, 32'h0, 4'h0, 32'h83ff0155, 32'hffffffff, 1'b0);
      begin
        repeat (4) @(posedge clock);
        ce <= 1'b1;
      end
    join
    $display("test clock enable done");
    // A reset in mid-run must clear the enables again.
    srst <= 1'b1;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    apb(1'b0, 16'h12f8, 32'h0, 4'h0, 32'h83ff0000, 32'hffffffff, 1'b0);
    repeat (2) @(posedge clock);
    $display("test reset done");
    stop_test;
  end
endmodule

// *** hdl/embedder_defines.svh ***
`ifndef EMBEDDER_DEFINES_SVH
`define EMBEDDER_DEFINES_SVH

// Register offset and field positions, numbered with bit 0 as the LSB.
`define SELECT_OFFSET   16'h12f8
`define PRESENCE_BIT    31
`define AVAIL_LSB       16
`define ABS_BIT         15
`define ENABLE_LSB      0
`define ITEM_COUNT      10
`define ENABLE_RESET    10'h000
`define AVAIL_DEFAULT   10'h3ff

// Timestamp ranges and field positions.
`define SUB_MAX_DEFAULT 12'hbff
`define CYC_MAX         13'h1f3f
`define SEC_MAX         7'h7f
`define SEC_LSB         25
`define CYC_LSB         12
`define FRAME_SUB_BITS  4
`define GPIO_WIDTH      4
`endif

// *** hdl/embedder_pkg.sv ***
package embedder_pkg;

  // One embedded metadata word.
  typedef logic [31:0] word_t;

  // Items in emission order; the enum position is also the enable bit index.
  typedef enum logic [3:0] {
    ITEM_TIME, ITEM_GAIN, ITEM_SHUTTER, ITEM_BRIGHT, ITEM_EXPOSURE,
    ITEM_WBAL, ITEM_FRAME, ITEM_STROBE, ITEM_PINS, ITEM_REGION
  } item_e;

  // Where the inserter stands within the current frame.
  typedef enum logic [1:0] {EMIT_IDLE, EMIT_META, EMIT_PASS} emit_e;

endpackage

// *** hdl/frame_metadata_embedder.sv ***
`timescale 1ns/1ns
`include "embedder_defines.svh"
module frame_metadata_embedder #(
  parameter int          ADDR_W        = 16,               // APB address width.
  parameter logic [9:0]  ITEM_AVAIL    = `AVAIL_DEFAULT,   // Per-item availability.
  parameter logic        ABS_SUPPORTED = 1'b0,             // Absolute values offered.
  parameter logic        MONO          = 1'b0,             // Monochrome sensor.
  parameter logic        TS_FRAME_SUB  = 1'b0,             // Frame count in stamp LSBs.
  parameter logic [11:0] SUB_MAX       = `SUB_MAX_DEFAULT, // Last sub-cycle tick.
  parameter int          GPIO_W        = `GPIO_WIDTH       // Number of sampled pins.
) (
  input  wire logic              clock,             // Pixel clock, 50 MHz.
  input  wire logic              srst,              // Synchronous reset, active high.
  input  wire logic              ce,                // Clock enable, freezes all state.
  input  wire logic              psel,              // APB select.
  input  wire logic              penable,           // APB access phase.
  input  wire logic              pwrite,            // APB write.
  input  wire logic [ADDR_W-1:0] paddr,             // APB byte address.
  input  wire logic [31:0]       pwdata,            // APB write data.
  input  wire logic [3:0]        pstrb,             // APB byte strobes.
  output logic      [31:0]       prdata,            // APB read data.
  output logic                   pready,            // APB ready.
  output logic                   pslverr,           // APB error, unmapped address.
  input  wire logic [7:0]        inPixel,           // Pixel from the pipeline.
  input  wire logic              inValid,           // Pixel valid.
  input  wire logic              inSof,             // First pixel of a frame.
  output logic      [7:0]        outPixel,          // Pixel toward the camera bus.
  output logic                   outValid,          // Output pixel valid.
  output logic                   outSof,            // Output first pixel of frame.
  input  wire logic              integrationEnd,    // Shutter integration ended.
  input  wire logic [31:0]       gainValue,         // Current gain word.
  input  wire logic [31:0]       shutterValue,      // Current shutter word.
  input  wire logic [31:0]       brightnessValue,   // Current brightness word.
  input  wire logic [31:0]       exposureValue,     // Current exposure word.
  input  wire logic [31:0]       whiteBalanceValue, // Current white balance word.
  input  wire logic [31:0]       strobeCount,       // Strobe pattern counter.
  input  wire logic [15:0]       regionLeft,        // Region shift from left border.
  input  wire logic [15:0]       regionTop,         // Region shift from top border.
  input  wire logic [GPIO_W-1:0] gpioPins           // Asynchronous pin levels.
);
  import embedder_pkg::*;

  localparam int N = `ITEM_COUNT;

  // Picks byte lane 0..3 of a word, lane 0 being the most significant byte.
  function automatic logic [7:0] pickByte(input word_t w, input logic [1:0] lane);
    logic [7:0] b;
    b = 8'h00;
    case (lane)
      2'h0: b = w[31:24];
      2'h1: b = w[23:16];
      2'h2: b = w[15:8];
      default: b = w[7:0];
    endcase
    return b;
  endfunction

  // Timestamp chain and pin synchroniser.
  word_t             stamp;
  logic [GPIO_W-1:0] pinState;

  timestamp_counter #(
    .SUB_MAX (SUB_MAX)
  ) u_stamp (
    .clock (clock),
    .srst  (srst),
    .ce    (ce),
    .stamp (stamp)
  );

  pin_sync3 #(
    .W (GPIO_W)
  ) u_pins (
    .clock  (clock),
    .srst   (srst),
    .ce     (ce),
    .pinIn  (gpioPins),
    .pinOut (pinState)
  );

  // APB slave for the single select register.
  // An access is answered one cycle after the slave first sees it selected with the clock enable high,
  // so a setup edge lost to a low clock enable cannot leave the master waiting forever.
  logic [9:0] enableReg;
  wire        answerNext = psel && !pready;
  wire        accessDone = psel && penable && pready;
  wire        addrHit    = (paddr == ADDR_W'(`SELECT_OFFSET));
  wire        writeHit   = accessDone && pwrite && addrHit;

  // Readback: presence, availability, value kind and enables; the rest reads zero.
  wire [31:0] readValue  = {1'b1, 5'h00, ITEM_AVAIL, ABS_SUPPORTED, 5'h00, enableReg};

  // Byte lanes 0 and 1 hold the enables; unavailable items cannot be switched on.
  wire [9:0]  enableNext = {pstrb[1] ? pwdata[9:8] : enableReg[9:8],
                            pstrb[0] ? pwdata[7:0] : enableReg[7:0]} & ITEM_AVAIL;

  // Normally the answer is prepared in the setup cycle, so an access has no wait state.
  always_ff @(posedge clock) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= answerNext;
      pslverr <= answerNext && !addrHit;
      prdata  <= (answerNext && !pwrite && addrHit) ? readValue : 32'h0000_0000;
    end
  end

  // A write lands only at the completing edge of the access phase.
  always_ff @(posedge clock) begin
    if (srst) begin
      enableReg <= `ENABLE_RESET;
    end else if (ce && writeHit) begin
      enableReg <= enableNext;
    end
  end

  // Parameter capture: live values, the snapshot and the copy used by the frame on the wire.
  logic [31:0] frameCountReg;
  word_t       liveWord     [N];
  word_t       pendWord     [N];
  word_t       frameWordReg [N];
  word_t       curWord      [N];
  logic [9:0]  frameMaskReg;

  // Values as they stand now; white balance keeps its slot on mono parts.
  assign liveWord[ITEM_TIME]     = TS_FRAME_SUB ? {stamp[31:`FRAME_SUB_BITS],
                                   frameCountReg[`FRAME_SUB_BITS-1:0]} : stamp;
  assign liveWord[ITEM_GAIN]     = gainValue;
  assign liveWord[ITEM_SHUTTER]  = shutterValue;
  assign liveWord[ITEM_BRIGHT]   = brightnessValue;
  assign liveWord[ITEM_EXPOSURE] = exposureValue;
  assign liveWord[ITEM_WBAL]     = MONO ? 32'h0000_0000 : whiteBalanceValue;
  assign liveWord[ITEM_FRAME]    = frameCountReg;
  assign liveWord[ITEM_STROBE]   = strobeCount;
  assign liveWord[ITEM_PINS]     = {{(32-GPIO_W){1'b0}}, pinState};
  assign liveWord[ITEM_REGION]   = {regionLeft, regionTop};

  // Frame counter advances at each integration end, after its value is captured.
  always_ff @(posedge clock) begin
    if (srst) begin
      frameCountReg <= 32'h0000_0000;
    end else if (ce && integrationEnd) begin
      frameCountReg <= frameCountReg + 32'h0000_0001;
    end
  end

  // Insertion of the packed words ahead of the image pixels.
  emit_e      stateReg;
  logic [5:0] byteIdxReg;
  word_t      packedWord [N];
  logic [3:0] slotCnt;

  // Pending words snap at integration end; the frame copy is taken at frame start,
  // so a late integration end cannot tear a frame already on its way out.
  for (genvar gi = 0; gi < N; gi++) begin : g_words
    always_ff @(posedge clock) begin
      if (srst) begin
        pendWord[gi]     <= 32'h0000_0000;
        frameWordReg[gi] <= 32'h0000_0000;
      end else if (ce) begin
        if (integrationEnd) begin
          pendWord[gi] <= liveWord[gi];
        end
        if (inValid && inSof) begin
          frameWordReg[gi] <= pendWord[gi];
        end
      end
    end
    assign curWord[gi] = inSof ? pendWord[gi] : frameWordReg[gi];
  end

  // On the first pixel the live mask and pending words are used directly.
  wire [9:0] curMask = inSof ? enableReg : frameMaskReg;

  // Enabled items are packed in emission order into consecutive slots.
  always_comb begin
    slotCnt = 4'h0;
    for (int i = 0; i < N; i++) begin
      packedWord[i] = 32'h0000_0000;
    end
    for (int i = 0; i < N; i++) begin
      if (curMask[i]) begin
        packedWord[slotCnt] = curWord[i];
        slotCnt = slotCnt + 4'h1;
      end
    end
  end

  wire [5:0] metaBytes = {slotCnt, 2'b00};
  wire [5:0] curIdx    = inSof ? 6'h00 : byteIdxReg;
  wire       inMeta    = inSof ? (metaBytes != 6'h00) : (stateReg == EMIT_META);
  wire       lastMeta  = inMeta && (curIdx == metaBytes - 6'h01);
  wire [7:0] metaByte  = pickByte(packedWord[curIdx[5:2]], curIdx[1:0]);
  wire [7:0] pixelNext = inMeta ? metaByte : inPixel;

  // Metadata overwrites the leading pixels; the row is assumed to hold at least 40 pixels.
  always_ff @(posedge clock) begin
    if (srst) begin
      stateReg     <= EMIT_IDLE;
      byteIdxReg   <= 6'h00;
      frameMaskReg <= `ENABLE_RESET;
    end else if (ce && inValid) begin
      if (inSof) begin
        frameMaskReg <= enableReg;
      end
      if (inMeta) begin
        stateReg   <= lastMeta ? EMIT_PASS : EMIT_META;
        byteIdxReg <= curIdx + 6'h01;
      end else if (inSof) begin
        stateReg <= EMIT_PASS;
      end
    end
  end

  // Output stage: one register between pipeline and bus.
  always_ff @(posedge clock) begin
    if (srst) begin
      outPixel <= 8'h00;
      outValid <= 1'b0;
      outSof   <= 1'b0;
    end else if (ce) begin
      outPixel <= pixelNext;
      outValid <= inValid;
      outSof   <= inValid && inSof;
    end
  end

  // Checks on the bus answer, the register image and the inserted stream.
  // They watch the bus, clock enable and pixel inputs as well as what this block drives, and hold for any legal stimulus.
  sequence apbSetupS;
    psel && !penable && ce;
  endsequence

  sequence apbAnswerS;
    pready ##1 !pready;
  endsequence

  apb_answer_a: assert property (@(posedge clock) disable iff (srst)
    apbSetupS ##1 (penable && ce) |-> apbAnswerS)
    else $error("APB answer was not a single ready cycle.");

  reserved_zero_a: assert property (@(posedge clock) disable iff (srst)
    pready |-> prdata[30:26] == 5'h00 && prdata[14:10] == 5'h00)
    else $error("Reserved register bits read nonzero.");

  presence_read_a: assert property (@(posedge clock) disable iff (srst)
    pready && !pslverr && !pwrite |-> prdata[`PRESENCE_BIT] && prdata[25:16] == ITEM_AVAIL)
    else $error("Presence or availability flags read wrong.");

  enable_avail_a: assert property (@(posedge clock) disable iff (srst)
    ce && writeHit |=> enableReg == (ITEM_AVAIL & $past(enableNext)) && (enableReg & ~ITEM_AVAIL) == 10'h000)
    else $error("Unavailable item enable was stored.");

  capture_hold_a: assert property (@(posedge clock) disable iff (srst)
    !(ce && integrationEnd) |=> pendWord[ITEM_SHUTTER] == $past(pendWord[ITEM_SHUTTER]))
    else $error("Captured value changed without integration end.");

  first_byte_a: assert property (@(posedge clock) disable iff (srst)
    ce && inValid && inSof && metaBytes != 6'h00 |=> outSof && outPixel == $past(packedWord[0][31:24]))
    else $error("First metadata byte missing at column zero.");

  meta_count_a: assert property (@(posedge clock) disable iff (srst)
    ce && inValid && inSof && enableReg == 10'h3ff |-> metaBytes == 6'h28)
    else $error("All items enabled did not give forty bytes.");

  shutter_only_a: assert property (@(posedge clock) disable iff (srst)
    ce && inValid && inSof && enableReg == 10'h004 |=> outPixel == $past(pendWord[ITEM_SHUTTER][31:24]))
    else $error("Lone shutter word not packed at byte zero.");

  pass_through_a: assert property (@(posedge clock) disable iff (srst)
    ce && inValid && !inSof && stateReg == EMIT_PASS |=> outPixel == $past(inPixel))
    else $error("Image pixel altered after metadata.");

  sequence accessWaitS;
    psel && penable && !pready && ce;
  endsequence

  sequence shutterStartS;
    ce && inValid && inSof && enableReg == 10'h004;
  endsequence

  wait_answer_a: assert property (@(posedge clock) disable iff (srst)
    accessWaitS |=> pready)
    else $error("Stalled APB access was never answered.");

  abs_flag_a: assert property (@(posedge clock) disable iff (srst)
    pready && !pslverr && !pwrite |-> prdata[`ABS_BIT] == ABS_SUPPORTED)
    else $error("Absolute value flag read wrong.");

  frame_step_a: assert property (@(posedge clock) disable iff (srst)
    ce && integrationEnd |=> frameCountReg == $past(frameCountReg) + 32'h0000_0001)
    else $error("Frame counter did not advance at integration end.");

  meta_end_a: assert property (@(posedge clock) disable iff (srst)
    ce && inValid && lastMeta |=> stateReg == EMIT_PASS)
    else $error("Metadata did not end after its last byte.");

  stream_delay_a: assert property (@(posedge clock) disable iff (srst)
    ce |=> outValid == $past(inValid) && outSof == $past(inValid && inSof))
    else $error("Output stream is not the input delayed by one cycle.");

  byte_order_a: assert property (@(posedge clock) disable iff (srst)
    shutterStartS ##1 (ce && inValid && !inSof) |=> outPixel == frameWordReg[ITEM_SHUTTER][23:16])
    else $error("Second metadata byte is not bits 23 to 16.");
endmodule

// *** hdl/pin_sync3.sv ***
`timescale 1ns/1ns
module pin_sync3 #(
  parameter int W = 4
) (
  input  wire logic         clock, // Pixel clock.
  input  wire logic         srst,  // Synchronous reset, active high.
  input  wire logic         ce,    // Clock enable.
  input  wire logic [W-1:0] pinIn, // Asynchronous pin levels.
  output logic      [W-1:0] pinOut // Filtered pin levels.
);
  logic [W-1:0] stage1Reg;
  logic [W-1:0] stage2Reg;
  logic [W-1:0] stage3Reg;
  wire  [W-1:0] agree = ~(stage2Reg ^ stage3Reg);

  // Stage one is read only by stage two; a bit moves once stages two and three agree.
  always_ff @(posedge clock) begin
    if (srst) begin
      stage1Reg <= '0;
      stage2Reg <= '0;
      stage3Reg <= '0;
      pinOut    <= '0;
    end else if (ce) begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      pinOut    <= (agree & stage3Reg) | (~agree & pinOut);
    end
  end
endmodule

// *** hdl/timestamp_counter.sv ***
`timescale 1ns/1ns
`include "embedder_defines.svh"
module timestamp_counter #(
  parameter logic [11:0] SUB_MAX = `SUB_MAX_DEFAULT
) (
  input  wire logic        clock, // Pixel clock.
  input  wire logic        srst,  // Synchronous reset, active high.
  input  wire logic        ce,    // Clock enable.
  output logic      [31:0] stamp  // Seconds, cycle and sub-cycle fields.
);
  logic [11:0] subReg;
  logic [12:0] cycReg;
  logic [6:0]  secReg;

  // Wrap detection of each stage of the chain.
  wire subWrap = (subReg == SUB_MAX);
  wire cycWrap = (cycReg == `CYC_MAX);
  wire secWrap = (secReg == `SEC_MAX);

  // The chain only carries on a sub-cycle wrap, so all fields move coherently.
  always_ff @(posedge clock) begin
    if (srst) begin
      subReg <= '0;
      cycReg <= '0;
      secReg <= '0;
    end else if (ce) begin
      subReg <= subWrap ? 12'h000 : subReg + 12'h001;
      if (subWrap) begin
        cycReg <= cycWrap ? 13'h0000 : cycReg + 13'h0001;
        if (cycWrap) begin
          secReg <= secWrap ? 7'h00 : secReg + 7'h01;
        end
      end
    end
  end

  assign stamp = {secReg, cycReg, subReg};

  sub_wrap_a: assert property (@(posedge clock) disable iff (srst)
    ce && subWrap |=> subReg == 12'h000)
    else $error("Sub-cycle tick did not wrap at its maximum.");

  cyc_step_a: assert property (@(posedge clock) disable iff (srst)
    ce && subWrap && !cycWrap |=> cycReg == $past(cycReg) + 13'h0001)
    else $error("Cycle tick did not advance on sub-cycle wrap.");

  sec_wrap_a: assert property (@(posedge clock) disable iff (srst)
    ce && subWrap && cycWrap && secWrap |=> secReg == 7'h00 && cycReg == 13'h0000)
    else $error("Seconds field did not wrap after 127.");
endmodule
